// ---- src/shc_pkg.sv ----
`default_nettype none
package shc_pkg;

   // Register map
   localparam logic [15:0] ADDR_SYS_CMD = 16'h1000;
   localparam logic [15:0] ADDR_PWR_IF = 16'h1001;
   localparam logic [15:0] ADDR_EV_MASK = 16'h1002;
   localparam logic [15:0] ADDR_LP_WD = 16'h1003;
   localparam logic [15:0] ADDR_SENSE0 = 16'h1012;
   localparam logic [15:0] ADDR_SENSE1 = 16'h1013;
   localparam logic [15:0] ADDR_PROX_DB = 16'h1028;
   localparam logic [15:0] ADDR_PM_FLAGS = 16'h2000;
   localparam logic [15:0] ADDR_DEV_STAT = 16'h2001;
   localparam logic [15:0] ADDR_EV_FLAGS = 16'h2002;

   // System command bit positions
   localparam int CMD_HAPTIC = 5;
   localparam int CMD_RESEED = 4;
   localparam int CMD_CAL = 2;
   localparam int CMD_SRST = 1;
   localparam int CMD_ACK = 0;

   // Writable bits; reserved bits are stored as zero
   localparam logic [7:0] WMASK_SYS_CMD = 8'h37;
   localparam logic [7:0] WMASK_PWR_IF = 8'hE7;
   localparam logic [7:0] WMASK_EV_MASK = 8'h1F;
   localparam logic [7:0] WMASK_LP_WD = 8'h7F;
   localparam logic [7:0] WMASK_SENSE0 = 8'hF0;
   localparam logic [7:0] WMASK_SENSE1 = 8'hFF;
   localparam logic [7:0] WMASK_PROX_DB = 8'hFF;

   // Reset values
   localparam logic [7:0] RST_PWR_IF = 8'h00;
   localparam logic [7:0] RST_EV_MASK = 8'h00;
   localparam logic [7:0] RST_LP_WD = 8'h00;
   localparam logic [7:0] RST_SENSE0 = 8'h00;
   localparam logic [7:0] RST_SENSE1 = 8'h00;
   localparam logic [7:0] RST_PROX_DB = 8'h00;
   localparam logic [7:0] RD_ZERO = 8'h00;

   // Watchdog periods in milliseconds for codes 1..7
   localparam logic [15:0] WD_MS_OFF = 16'h0000;
   localparam logic [15:0] WD_MS_1 = 16'h0032;
   localparam logic [15:0] WD_MS_2 = 16'h007D;
   localparam logic [15:0] WD_MS_3 = 16'h00FA;
   localparam logic [15:0] WD_MS_4 = 16'h01F4;
   localparam logic [15:0] WD_MS_5 = 16'h03E8;
   localparam logic [15:0] WD_MS_6 = 16'h07D0;
   localparam logic [15:0] WD_MS_7 = 16'h0FA0;

   // Autonomous conversions per full update, code 0 value
   localparam logic [5:0] CONV_BASE = 6'h04;

   localparam logic [2:0] SENSE_OFF = 3'h0;
   localparam logic [2:0] SENSE_SELF_CAP = 3'h3;
   localparam logic [2:0] SENSE_INDUCT = 3'h4;

   typedef enum logic [1:0] {
      IF_STREAM = 2'h0,
      IF_EVENT = 2'h1,
      IF_RSVD = 2'h2,
      IF_STANDALONE = 2'h3
   } shc_if_e;

   typedef enum logic [2:0] {
      PM_NORMAL = 3'h0,
      PM_ULTRA_LOW = 3'h1,
      PM_AUTO = 3'h2,
      PM_HALT = 3'h3
   } shc_pm_e;

   typedef enum logic [1:0] {
      CAL_OFF = 2'h0,
      CAL_DIV = 2'h1,
      CAL_COMP = 2'h2,
      CAL_DIV_COMP = 2'h3
   } shc_cal_e;

   typedef struct packed {
      logic term_on_stop;
      shc_if_e if_sel;
      shc_pm_e power_mode;
      logic [4:0] event_mask;
      logic ro_check_en;
      logic [2:0] wd_code;
      logic lp_conv_en;
      logic [1:0] conv_code;
      shc_cal_e cal_mode;
      logic dual_thr;
      logic inverse;
      logic osc_tx;
      logic [2:0] sense_mode;
      logic [3:0] conv_freq;
      logic [3:0] db_exit;
      logic [3:0] db_enter;
   } shc_cfg_s;

endpackage : shc_pkg

`default_nettype wire

// ---- src/shc_regs.sv ----
// Functional notes
// - Writing one to haptic trigger bit starts an effect; bit self-clears.
// - Writing one to reseed bit reloads baseline average, bit self-clears.
// - Writing one to calibration bit launches auto tuning, bit self-clears.
// - Writing one to soft reset bit resets the device, bit self-clears.
// - Host acks reset by writing ack bit; device records it, self-clears.
// - Terminate-on-stop one closes window on bus stop; zero keeps it open.
// - Interface select 0 opens a window every measurement cycle.
// - Interface select 1 opens a window only on an enabled event.
// - Interface select 2 reserved; 3 is standalone with bus disabled.
// - Power mode field: normal, ultra-low, automatic, halt for 0 to 3.
// - Five mask bits enable windows on haptic, touch, prox, cal, power.
// - Watchdog field: off, then 50 to 4000 ms for codes 1 to 7.
// - One bit enables autonomous low-power conversions in ultra-low power.
// - Update all channels after 4, 8, 16 or 32 autonomous conversions.
// - One bit enables the read-only consistency check.
// - Calibration mode: off, divider, compensation, or both.
// - Dual threshold lets button events trigger on both delta signs.
// - Inverse makes button events trigger on negative deltas.
// - Sensing mode: 0 off, 3 self-capacitance, 4 inductance.
// - Four-bit conversion frequency field sets the sensing rate.
// - Oscillator-rate transmit bit runs transmit at oscillator frequency.
// - Debounce: upper nibble samples to exit, lower to enter proximity.
// - Event flags set on their event and clear when the host reads them.
// - A status flag shows that a system reset event occurred.
`timescale 1ns/10ps
`default_nettype none

module shc_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h44
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic i_meas_cycle,
   input wire logic [4:0] i_events,
   output logic o_comms_window,
   output logic o_bus_enable,
   output shc_pkg::shc_cfg_s o_cfg,
   output logic [15:0] o_wd_period_ms,
   output logic [5:0] o_conv_count,
   output logic o_sense_self_cap,
   output logic o_sense_induct,
   output logic o_haptic_start,
   output logic o_reseed_baseline,
   output logic o_calibrate,
   output logic o_soft_reset
);

   typedef enum {
      ST_IDLE,
      ST_DEV,
      ST_DEV_ACK,
      ST_AHI,
      ST_AHI_ACK,
      ST_ALO,
      ST_ALO_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RMACK
   } shc_bus_e;

   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Bus pin synchronisers and edge history
   logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
   logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
   // Bus engine state
   shc_bus_e st_reg, st_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg, sh_next;
   logic [15:0] ptr_reg, ptr_next;
   logic rw_reg, rw_next;
   logic oe_reg, oe_next;
   logic mack_reg, mack_next;
   // Strobes from bus engine to register bank
   logic wr_stb, rd_stb, stop_seen;
   logic [7:0] rd_data;
   // Register bank state
   logic [7:0] cmd_reg, cmd_next;
   logic [7:0] pwr_reg, pwr_next;
   logic [7:0] mask_reg, mask_next;
   logic [7:0] lpwd_reg, lpwd_next;
   logic [7:0] sen0_reg, sen0_next;
   logic [7:0] sen1_reg, sen1_next;
   logic [7:0] db_reg, db_next;
   logic [4:0] ev_reg, ev_next;
   logic rst_seen_reg, rst_seen_next;
   logic win_reg, win_next;

   logic scl_rise, scl_fall, bus_start, bus_stop, bus_en;
   shc_pkg::shc_if_e if_sel;

   function automatic logic [15:0] wd_ms(input logic [2:0] code);
      unique case (code)
         3'h0: wd_ms = shc_pkg::WD_MS_OFF;
         3'h1: wd_ms = shc_pkg::WD_MS_1;
         3'h2: wd_ms = shc_pkg::WD_MS_2;
         3'h3: wd_ms = shc_pkg::WD_MS_3;
         3'h4: wd_ms = shc_pkg::WD_MS_4;
         3'h5: wd_ms = shc_pkg::WD_MS_5;
         3'h6: wd_ms = shc_pkg::WD_MS_6;
         3'h7: wd_ms = shc_pkg::WD_MS_7;
      endcase
   endfunction : wd_ms

   function automatic logic [7:0] masked(input logic [7:0] data,
                                          input logic [7:0] wmask);
      masked = data & wmask;
   endfunction : masked

   // Field decode of the stored registers
   always_comb begin
      o_cfg.term_on_stop = pwr_reg[7];
      o_cfg.if_sel = shc_pkg::shc_if_e'(pwr_reg[6:5]);
      o_cfg.power_mode = shc_pkg::shc_pm_e'(pwr_reg[2:0]);
      o_cfg.event_mask = mask_reg[4:0];
      o_cfg.ro_check_en = lpwd_reg[6];
      o_cfg.wd_code = lpwd_reg[5:3];
      o_cfg.lp_conv_en = lpwd_reg[2];
      o_cfg.conv_code = lpwd_reg[1:0];
      o_cfg.cal_mode = shc_pkg::shc_cal_e'(sen0_reg[7:6]);
      o_cfg.dual_thr = sen0_reg[5];
      o_cfg.inverse = sen0_reg[4];
      o_cfg.osc_tx = sen1_reg[7];
      o_cfg.sense_mode = sen1_reg[6:4];
      o_cfg.conv_freq = sen1_reg[3:0];
      o_cfg.db_exit = db_reg[7:4];
      o_cfg.db_enter = db_reg[3:0];
   end

   assign if_sel = shc_pkg::shc_if_e'(pwr_reg[6:5]);
   assign bus_en = (if_sel != shc_pkg::IF_STANDALONE);
   assign o_bus_enable = bus_en;
   assign o_wd_period_ms = wd_ms(lpwd_reg[5:3]);
   assign o_conv_count = shc_pkg::CONV_BASE << lpwd_reg[1:0];
   assign o_sense_self_cap =
      (sen1_reg[6:4] == shc_pkg::SENSE_SELF_CAP);
   assign o_sense_induct =
      (sen1_reg[6:4] == shc_pkg::SENSE_INDUCT);
   assign o_comms_window = win_reg;
   assign o_haptic_start = cmd_reg[shc_pkg::CMD_HAPTIC];
   assign o_reseed_baseline = cmd_reg[shc_pkg::CMD_RESEED];
   assign o_calibrate = cmd_reg[shc_pkg::CMD_CAL];
   assign o_soft_reset = cmd_reg[shc_pkg::CMD_SRST];
   assign o_sda_out = 1'b0;
   assign o_sda_oe = oe_reg;

   assign scl_rise = scl_sync_reg & ~scl_prev_reg;
   assign scl_fall = ~scl_sync_reg & scl_prev_reg;
   assign bus_start = scl_sync_reg & scl_prev_reg & sda_prev_reg
                      & ~sda_sync_reg;
   assign bus_stop = scl_sync_reg & scl_prev_reg & ~sda_prev_reg
                     & sda_sync_reg;
   assign stop_seen = bus_stop & bus_en;

   // Read mux; unmapped and write-only addresses read zero
   always_comb begin
      unique case (ptr_reg)
         shc_pkg::ADDR_PWR_IF: rd_data = pwr_reg;
         shc_pkg::ADDR_EV_MASK: rd_data = mask_reg;
         shc_pkg::ADDR_LP_WD: rd_data = lpwd_reg;
         shc_pkg::ADDR_SENSE0: rd_data = sen0_reg;
         shc_pkg::ADDR_SENSE1: rd_data = sen1_reg;
         shc_pkg::ADDR_PROX_DB: rd_data = db_reg;
         shc_pkg::ADDR_PM_FLAGS: rd_data = {6'h00, pwr_reg[1:0]};
         shc_pkg::ADDR_DEV_STAT: rd_data = {7'h00, rst_seen_reg};
         shc_pkg::ADDR_EV_FLAGS: rd_data = {3'h0, ev_reg};
         default: rd_data = shc_pkg::RD_ZERO;
      endcase
   end

   // Serial bus engine: 7-bit address, 16-bit register pointer, auto-increment
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      ptr_next = ptr_reg;
      rw_next = rw_reg;
      oe_next = oe_reg;
      mack_next = mack_reg;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      if (!bus_en) begin
         st_next = ST_IDLE;
         oe_next = 1'b0;
      end else if (bus_start) begin
         st_next = ST_DEV;
         cnt_next = 4'h0;
         oe_next = 1'b0;
      end else if (bus_stop) begin
         st_next = ST_IDLE;
         oe_next = 1'b0;
      end else if (scl_rise) begin
         unique case (st_reg)
            ST_DEV, ST_AHI, ST_ALO, ST_WDATA: begin
               sh_next = {sh_reg[6:0], sda_sync_reg};
               cnt_next = cnt_reg + 4'h1;
            end
            ST_RMACK: mack_next = ~sda_sync_reg;
            default: ;
         endcase
      end else if (scl_fall) begin
         unique case (st_reg)
            ST_DEV: begin
               if (cnt_reg == BITS_PER_BYTE) begin
                  if (sh_reg[7:1] == DEV_ADDR) begin
                     st_next = ST_DEV_ACK;
                     oe_next = 1'b1;
                     rw_next = sh_reg[0];
                  end else begin
                     st_next = ST_IDLE;
                  end
               end
            end
            ST_AHI: begin
               if (cnt_reg == BITS_PER_BYTE) begin
                  st_next = ST_AHI_ACK;
                  oe_next = 1'b1;
                  ptr_next = {sh_reg, ptr_reg[7:0]};
               end
            end
            ST_ALO: begin
               if (cnt_reg == BITS_PER_BYTE) begin
                  st_next = ST_ALO_ACK;
                  oe_next = 1'b1;
                  ptr_next = {ptr_reg[15:8], sh_reg};
               end
            end
            ST_WDATA: begin
               if (cnt_reg == BITS_PER_BYTE) begin
                  st_next = ST_WDATA_ACK;
                  oe_next = 1'b1;
                  wr_stb = 1'b1;
                  ptr_next = ptr_reg + 16'h0001;
               end
            end
            ST_DEV_ACK, ST_RMACK: begin
               if (st_reg == ST_RMACK && !mack_reg) begin
                  st_next = ST_IDLE;
                  oe_next = 1'b0;
               end else if (rw_reg) begin
                  st_next = ST_RDATA;
                  rd_stb = 1'b1;
                  sh_next = rd_data;
                  oe_next = ~rd_data[7];
                  cnt_next = 4'h1;
                  ptr_next = ptr_reg + 16'h0001;
               end else begin
                  st_next = ST_AHI;
                  oe_next = 1'b0;
                  cnt_next = 4'h0;
               end
            end
            ST_AHI_ACK: begin
               st_next = ST_ALO;
               oe_next = 1'b0;
               cnt_next = 4'h0;
            end
            ST_ALO_ACK, ST_WDATA_ACK: begin
               st_next = ST_WDATA;
               oe_next = 1'b0;
               cnt_next = 4'h0;
            end
            ST_RDATA: begin
               if (cnt_reg == BITS_PER_BYTE) begin
                  st_next = ST_RMACK;
                  oe_next = 1'b0;
                  mack_next = 1'b0;
               end else begin
                  oe_next = ~sh_reg[6];
                  sh_next = {sh_reg[6:0], 1'b0};
                  cnt_next = cnt_reg + 4'h1;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         st_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         sh_reg <= 8'h00;
         ptr_reg <= 16'h0000;
         rw_reg <= 1'b0;
         oe_reg <= 1'b0;
         mack_reg <= 1'b0;
      end else begin
         scl_meta_reg <= i_scl;
         scl_sync_reg <= scl_meta_reg;
         scl_prev_reg <= scl_sync_reg;
         sda_meta_reg <= i_sda;
         sda_sync_reg <= sda_meta_reg;
         sda_prev_reg <= sda_sync_reg;
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         ptr_reg <= ptr_next;
         rw_reg <= rw_next;
         oe_reg <= oe_next;
         mack_reg <= mack_next;
      end
   end

   // Register bank, command self-clear, event flags and window control
   always_comb begin
      logic srst;
      logic wr_cmd;
      logic ev_hit;
      srst = cmd_reg[shc_pkg::CMD_SRST];
      wr_cmd = wr_stb && (ptr_reg == shc_pkg::ADDR_SYS_CMD);
      ev_hit = |(i_events & mask_reg[4:0]);
      // Command bits live one cycle, then clear without host action
      cmd_next = 8'h00;
      if (wr_cmd) begin
         cmd_next = masked(sh_reg, shc_pkg::WMASK_SYS_CMD);
      end
      pwr_next = pwr_reg;
      mask_next = mask_reg;
      lpwd_next = lpwd_reg;
      sen0_next = sen0_reg;
      sen1_next = sen1_reg;
      db_next = db_reg;
      if (wr_stb) begin
         unique case (ptr_reg)
            shc_pkg::ADDR_PWR_IF:
               pwr_next = masked(sh_reg, shc_pkg::WMASK_PWR_IF);
            shc_pkg::ADDR_EV_MASK:
               mask_next = masked(sh_reg, shc_pkg::WMASK_EV_MASK);
            shc_pkg::ADDR_LP_WD:
               lpwd_next = masked(sh_reg, shc_pkg::WMASK_LP_WD);
            shc_pkg::ADDR_SENSE0:
               sen0_next = masked(sh_reg, shc_pkg::WMASK_SENSE0);
            shc_pkg::ADDR_SENSE1:
               sen1_next = masked(sh_reg, shc_pkg::WMASK_SENSE1);
            shc_pkg::ADDR_PROX_DB:
               db_next = masked(sh_reg, shc_pkg::WMASK_PROX_DB);
            default: ;
         endcase
      end
      // Clear on read; an event in the same cycle survives
      ev_next = ev_reg | i_events;
      if (rd_stb && ptr_reg == shc_pkg::ADDR_EV_FLAGS) begin
         ev_next = i_events;
      end
      rst_seen_next = rst_seen_reg;
      if (wr_cmd && sh_reg[shc_pkg::CMD_ACK]) begin
         rst_seen_next = 1'b0;
      end
      // Window: opens per mode, closes on stop or next cycle
      win_next = win_reg;
      if (stop_seen && pwr_reg[7]) begin
         win_next = 1'b0;
      end else if (i_meas_cycle && !pwr_reg[7]) begin
         win_next = 1'b0;
      end
      if (if_sel == shc_pkg::IF_STREAM && i_meas_cycle) begin
         win_next = 1'b1;
      end else if (if_sel == shc_pkg::IF_EVENT && ev_hit) begin
         win_next = 1'b1;
      end
      if (!bus_en) begin
         win_next = 1'b0;
      end
      // Soft reset re-initialises the bank and flags a reset event
      if (srst) begin
         pwr_next = shc_pkg::RST_PWR_IF;
         mask_next = shc_pkg::RST_EV_MASK;
         lpwd_next = shc_pkg::RST_LP_WD;
         sen0_next = shc_pkg::RST_SENSE0;
         sen1_next = shc_pkg::RST_SENSE1;
         db_next = shc_pkg::RST_PROX_DB;
         ev_next = i_events;
         rst_seen_next = 1'b1;
         win_next = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_reg <= 8'h00;
         pwr_reg <= shc_pkg::RST_PWR_IF;
         mask_reg <= shc_pkg::RST_EV_MASK;
         lpwd_reg <= shc_pkg::RST_LP_WD;
         sen0_reg <= shc_pkg::RST_SENSE0;
         sen1_reg <= shc_pkg::RST_SENSE1;
         db_reg <= shc_pkg::RST_PROX_DB;
         ev_reg <= 5'h00;
         rst_seen_reg <= 1'b1;
         win_reg <= 1'b0;
      end else begin
         cmd_reg <= cmd_next;
         pwr_reg <= pwr_next;
         mask_reg <= mask_next;
         lpwd_reg <= lpwd_next;
         sen0_reg <= sen0_next;
         sen1_reg <= sen1_next;
         db_reg <= db_next;
         ev_reg <= ev_next;
         rst_seen_reg <= rst_seen_next;
         win_reg <= win_next;
      end
   end

endmodule : shc_regs

`default_nettype wire

// ---- dv/shc_regs_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module shc_regs_chk (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_meas_cycle,
   input wire logic [4:0] i_events,
   input wire logic o_comms_window,
   input wire logic o_bus_enable,
   input wire shc_pkg::shc_cfg_s o_cfg,
   input wire logic [15:0] o_wd_period_ms,
   input wire logic [5:0] o_conv_count,
   input wire logic o_sense_self_cap,
   input wire logic o_sense_induct,
   input wire logic o_haptic_start,
   input wire logic o_reseed_baseline,
   input wire logic o_calibrate,
   input wire logic o_soft_reset
);
   localparam logic [15:0] WD_MS [8] = '{16'h0000, 16'h0032, 16'h007D,
      16'h00FA, 16'h01F4, 16'h03E8, 16'h07D0, 16'h0FA0};
   logic any_cmd;
   logic [4:0] hit;
   assign any_cmd = o_haptic_start || o_reseed_baseline || o_calibrate;
   assign hit = i_events & o_cfg.event_mask;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_stop;
      i_scl && $rose(i_sda);
   endsequence
   sequence s_quiet;
      (!i_meas_cycle && i_events == 5'h00)[*6];
   endsequence
   property p_stop;
      (o_cfg.term_on_stop && o_comms_window) ##0 s_stop ##1 s_quiet
         |=> !o_comms_window;
   endproperty
   property p_cmd;
      any_cmd |=> !any_cmd;
   endproperty
   property p_srst;
      (o_soft_reset && !i_meas_cycle && i_events == 5'h00)
         |=> (o_cfg == '0 && !o_comms_window);
   endproperty
   property p_stream;
      (o_cfg.if_sel == shc_pkg::IF_STREAM && i_meas_cycle && !o_soft_reset)
         |=> o_comms_window;
   endproperty
   property p_event;
      (o_cfg.if_sel == shc_pkg::IF_EVENT && hit != 5'h00 && !o_soft_reset)
         |=> o_comms_window;
   endproperty
   property p_no_open;
      (!o_comms_window && hit == 5'h00 &&
         o_cfg.if_sel inside {shc_pkg::IF_EVENT, shc_pkg::IF_RSVD})
         |=> !o_comms_window;
   endproperty
   property p_alone;
      (o_cfg.if_sel == shc_pkg::IF_STANDALONE)[*2]
         |-> (!o_comms_window && !o_bus_enable);
   endproperty
   property p_decode;
      o_wd_period_ms == WD_MS[o_cfg.wd_code] &&
         o_conv_count == (6'h04 << o_cfg.conv_code);
   endproperty
   property p_sense;
      o_sense_self_cap == (o_cfg.sense_mode == 3'h3) &&
         o_sense_induct == (o_cfg.sense_mode == 3'h4);
   endproperty
   a_stop: assert property (p_stop)
      else $error("window kept after stop");
   a_cmd: assert property (p_cmd)
      else $error("command pulse too long");
   a_srst: assert property (p_srst)
      else $error("soft reset left settings");
   a_stream: assert property (p_stream)
      else $error("no window on cycle");
   a_event: assert property (p_event)
      else $error("no window on event");
   a_no_open: assert property (p_no_open)
      else $error("window without event");
   a_alone: assert property (p_alone)
      else $error("standalone not honoured");
   a_decode: assert property (p_decode)
      else $error("period or count decode wrong");
   a_sense: assert property (p_sense)
      else $error("sensing mode decode wrong");
endmodule : shc_regs_chk
bind shc_regs shc_regs_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_scl(i_scl), .i_sda(i_sda), .i_meas_cycle(i_meas_cycle),
   .i_events(i_events), .o_comms_window(o_comms_window),
   .o_bus_enable(o_bus_enable), .o_cfg(o_cfg),
   .o_wd_period_ms(o_wd_period_ms), .o_conv_count(o_conv_count),
   .o_sense_self_cap(o_sense_self_cap), .o_sense_induct(o_sense_induct),
   .o_haptic_start(o_haptic_start), .o_reseed_baseline(o_reseed_baseline),
   .o_calibrate(o_calibrate), .o_soft_reset(o_soft_reset));
`default_nettype wire

// ---- dv/shc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module shc_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h44,
   parameter int Q = 5
) (
   input wire logic i_clk,
   input wire logic i_sda,
   output var logic o_scl,
   output var logic o_sda_oe
);
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   task automatic tq();
      repeat (Q) @(posedge i_clk);
      #1;
   endtask : tq
   task automatic bitx(input logic b, output logic r);
      tq();
      o_sda_oe = !b;
      tq();
      o_scl = 1'b1;
      tq();
      r = i_sda;
      o_scl = 1'b0;
   endtask : bitx
   task automatic start();
      tq();
      o_sda_oe = 1'b0;
      tq();
      o_scl = 1'b1;
      tq();
      o_sda_oe = 1'b1;
      tq();
      o_scl = 1'b0;
   endtask : start
   task automatic xfer(input logic [7:0] d, output logic [7:0] q,
      output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r);
         q[i] = r;
      end
      // Line released in the ninth bit: device ack, or host nack on reads
      bitx(1'b1, r);
      ack = !r;
   endtask : xfer
   task automatic access(input logic [15:0] a, input logic wr,
      input logic [7:0] wd, output logic [7:0] rd, output logic ok);
      logic [7:0] q;
      logic k;
      start();
      xfer({DEV_ADDR, 1'b0}, q, ok);
      xfer(a[15:8], q, k);
      xfer(a[7:0], q, k);
      if (wr) begin
         xfer(wd, q, k);
      end else begin
         start();
         xfer({DEV_ADDR, 1'b1}, q, k);
         xfer(8'hFF, rd, k);
      end
      tq();
      o_sda_oe = 1'b1;
      tq();
      o_scl = 1'b1;
      tq();
      o_sda_oe = 1'b0;
      tq();
      tq();
   endtask : access
endmodule : shc_host_model
`default_nettype wire

// ---- dv/test_sensor_haptic_control_registers.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_sensor_haptic_control_registers;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic meas = 1'b0;
   logic [4:0] ev = 5'h00;
   logic scl, h_oe, sda, sda_out, sda_oe, win, ben, hap, res, cal, srst;
   logic scap, sind, ack;
   shc_pkg::shc_cfg_s cfg;
   logic [15:0] wd, n;
   logic [5:0] conv;
   logic [7:0] rdat, d, v [6];
   logic [7:0] exp_q [$];
   logic [15:0] cnt [6] = '{default: 16'h0000};
   int error_cnt = 0;
   int checks = 0;
   event rd_done;
   localparam logic [15:0] ADR [6] = '{16'h1001, 16'h1002, 16'h1003,
      16'h1012, 16'h1013, 16'h1028};
   localparam logic [7:0] MSK [6] = '{8'hA7, 8'h1F, 8'h7F, 8'hF0, 8'hFF,
      8'hFF};
   localparam logic [15:0] WDT [8] = '{16'h0000, 16'h0032, 16'h007D,
      16'h00FA, 16'h01F4, 16'h03E8, 16'h07D0, 16'h0FA0};
   localparam int CMD [4] = '{5, 4, 2, 1};
   always #5 clk = ~clk;
   assign sda = !h_oe && (sda_oe ? sda_out : 1'b1);
   shc_regs dut (.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_meas_cycle(meas),
      .i_events(ev), .o_comms_window(win), .o_bus_enable(ben), .o_cfg(cfg),
      .o_wd_period_ms(wd), .o_conv_count(conv), .o_sense_self_cap(scap),
      .o_sense_induct(sind), .o_haptic_start(hap), .o_reseed_baseline(res),
      .o_calibrate(cal), .o_soft_reset(srst));
   shc_host_model host (.i_clk(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_oe(h_oe));
   always @(posedge clk) begin
      if (rst_n) begin
         cnt[5] <= cnt[5] + {15'h0000, hap};
         cnt[4] <= cnt[4] + {15'h0000, res};
         cnt[2] <= cnt[2] + {15'h0000, cal};
         cnt[1] <= cnt[1] + {15'h0000, srst};
      end
   end
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.access(a, 1'b0, 8'h00, rdat, ack);
      ->rd_done;
   endtask : rd
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      logic [7:0] q;
      host.access(a, 1'b1, v, q, ack);
   endtask : wr
   task automatic pulse(input logic m, input logic [4:0] e);
      @(posedge clk);
      #1;
      meas = m;
      ev = e;
      @(posedge clk);
      #1;
      meas = 1'b0;
      ev = 5'h00;
      @(posedge clk);
      #1;
   endtask : pulse
   task automatic end_of_test();
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test
   always @(rd_done) cmp({8'h00, rdat}, {8'h00, exp_q.pop_front()});
   initial begin
      repeat (80000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
   initial begin
      void'($urandom(99650));
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      rd(16'h2001, 8'h01);
      foreach (ADR[i]) rd(ADR[i], 8'h00);
      cmp({15'h0000, ben}, 16'h0001);
      wr(16'h1000, 8'h01);
      rd(16'h2001, 8'h00);
      repeat (2) foreach (ADR[i]) begin
         d = 8'($urandom()) & MSK[i];
         wr(ADR[i], d);
         v[i] = d;
         rd(ADR[i], d);
      end
      n = {v[0][7:5], v[0][2:0], v[1][4:0], v[2][6:2]};
      cmp(cfg[37:22], n);
      n = {v[2][1:0], v[3][7:4], v[4], v[5][7:6]};
      cmp(cfg[21:6], n);
      cmp({10'h000, cfg[5:0]}, {10'h000, v[5][5:0]});
      for (int i = 0; i < 8; i++) begin
         wr(16'h1003, {2'h0, i[2:0], 1'b0, i[1:0]});
         wr(16'h1013, {1'b0, i[2:0], 4'h7});
         cmp(wd, WDT[i]);
         cmp({10'h000, conv}, 16'h0004 << i[1:0]);
         cmp({14'h0000, sind, scap}, {14'h0000, i == 4, i == 3});
      end
      for (int i = 0; i < 4; i++) begin
         wr(16'h1001, 8'(i));
         rd(16'h2000, 8'(i));
      end
      wr(16'h1001, 8'h20);
      for (int i = 0; i < 5; i++) begin
         wr(16'h1002, 8'h01 << i);
         pulse(1'b0, ~(5'h01 << i));
         cmp({15'h0000, win}, 16'h0000);
         pulse(1'b0, 5'h01 << i);
         cmp({15'h0000, win}, 16'h0001);
         pulse(1'b1, 5'h00);
         cmp({15'h0000, win}, 16'h0000);
      end
      rd(16'h2002, 8'h1F);
      rd(16'h2002, 8'h00);
      wr(16'h1001, 8'h80);
      pulse(1'b1, 5'h00);
      cmp({15'h0000, win}, 16'h0001);
      rd(16'h2002, 8'h00);
      cmp({15'h0000, win}, 16'h0000);
      wr(16'h1001, 8'h00);
      pulse(1'b1, 5'h00);
      rd(16'h2002, 8'h00);
      cmp({15'h0000, win}, 16'h0001);
      foreach (CMD[k]) begin
         n = cnt[CMD[k]];
         wr(16'h1000, 8'h01 << CMD[k]);
         cmp(cnt[CMD[k]], n + 16'h0001);
         rd(16'h1000, 8'h00);
      end
      rd(16'h1002, 8'h00);
      rd(16'h2001, 8'h01);
      wr(16'h1001, 8'h60);
      cmp({15'h0000, ben}, 16'h0000);
      wr(16'h1001, 8'h00);
      cmp({15'h0000, ack}, 16'h0000);
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      rd(16'h1001, 8'h00);
      cmp({15'h0000, ben}, 16'h0001);
      end_of_test();
   end
endmodule : test_sensor_haptic_control_registers
`default_nettype wire
